// ---- mcuex_alu.v ----
// combinational result and flag unit for the execute subset
`timescale 1ns/1ps
`include "mcuex_regs.vh"
module mcuex_alu (
  input  wire [3:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] fval,
  input  wire [7:0] lit,
  input  wire       cin,
  input  wire       dcin,
  output reg  [7:0] res,
  output reg        cout,
  output reg        dcout,
  output wire       zout
);
  wire [8:0] diff;
  wire [4:0] ndiff;
  assign diff  = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
  assign ndiff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign zout  = (res == 8'h00);
  always @* begin
    res   = acc;
    cout  = cin;
    dcout = dcin;
    case (op)
      `MCUEX_OP_ROTL: begin
        res  = {fval[6:0], cin};
        cout = fval[7];
      end
      `MCUEX_OP_ROTR: begin
        res  = {cin, fval[7:1]};
        cout = fval[0];
      end
      `MCUEX_OP_SUB: begin
        res   = diff[7:0];
        cout  = diff[8];
        dcout = ndiff[4];
      end
      `MCUEX_OP_SWAP: res = {fval[3:0], fval[7:4]};
      `MCUEX_OP_XORL: res = acc ^ lit;
      `MCUEX_OP_XORF: res = acc ^ fval;
      `MCUEX_OP_RETLIT: res = lit;
      default: res = acc;
    endcase
  end
endmodule

// ---- mcuex_core.v ----
// execute subset of a small 8-bit core behind an ahb-lite slave
`timescale 1ns/1ps
`include "mcuex_regs.vh"
// How it works
// - load-prescaler copies accumulator into prescaler config, flags untouched.
// - return-with-literal loads accumulator with literal, pc from stack top, two cycles.
// - sleep clears watchdog counter and its prescaler.
// - sleep sets expiry flag, clears sleep-entered flag, keeps pin-wake flag.
// - after flag update sleep halts the processor and oscillator.
// - rotate left through carry, only carry flag changes.
// - rotate right through carry, only carry flag changes.
// - destination bit 0 writes accumulator, 1 writes file register.
// - subtract accumulator from file register, update carry, nibble and zero.
// - swap nibbles of source register, no flag change.
// - load pin direction register 6 or 7 from accumulator, no flags.
// - xor accumulator with literal into accumulator, update zero.
// - xor accumulator with file register to destination, update zero.
module mcuex_core (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [7:0]  prescaler_config_out,
  output reg  [7:0]  pin_direction6_out,
  output reg  [7:0]  pin_direction7_out,
  output reg  [8:0]  pc_out,
  output reg         pc_load_out,
  output reg         watchdog_clear_out,
  output reg         osc_halt_out
);
  // ************************************************************
  // state
  // ************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_HALT = 2'h3;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [15:0] cmd_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  file_r;
  reg  [8:0]  stack_r;
  reg  [7:0]  result_r;
  reg  [7:0]  watchdog_r;
  reg  [7:0]  presc_cnt_r;
  reg         carry_r;
  reg         nibble_r;
  reg         zero_r;
  reg         sleep_ent_r;
  reg         expiry_r;
  reg         pin_wake_r;
  reg  [1:0]  cyc_r;
  reg         wr_pend_r;
  reg  [7:0]  wr_addr_r;

  wire [3:0]  op;
  wire        dest;
  wire [7:0]  opnd;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire        xfer;
  wire [7:0]  status_w;

  assign op   = cmd_r[`MCUEX_OP_HI:`MCUEX_OP_LO];
  assign dest = cmd_r[`MCUEX_DEST_BIT];
  assign opnd = cmd_r[`MCUEX_OPND_HI:`MCUEX_OPND_LO];
  assign xfer = hsel & htrans[1] & hready;
  assign status_w = {state_r != ST_IDLE, state_r == ST_HALT, pin_wake_r, expiry_r,
                     sleep_ent_r, zero_r, nibble_r, carry_r};

  // ************************************************************
  // decode helpers
  // ************************************************************
  function uses_dest;
    input [3:0] o;
    begin
      uses_dest = (o == `MCUEX_OP_ROTL) | (o == `MCUEX_OP_ROTR) | (o == `MCUEX_OP_SUB) |
                  (o == `MCUEX_OP_SWAP) | (o == `MCUEX_OP_XORF);
    end
  endfunction

  function sets_zero;
    input [3:0] o;
    begin
      sets_zero = (o == `MCUEX_OP_SUB) | (o == `MCUEX_OP_XORL) | (o == `MCUEX_OP_XORF);
    end
  endfunction

  mcuex_alu u_alu (
    .op    (op),
    .acc   (acc_r),
    .fval  (file_r),
    .lit   (opnd),
    .cin   (carry_r),
    .dcin  (nibble_r),
    .res   (alu_res),
    .cout  (alu_c),
    .dcout (alu_dc),
    .zout  (alu_z)
  );

  // ************************************************************
  // execute sequencer
  // ************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_EXEC: begin
        if (op == `MCUEX_OP_RETLIT)
          state_nxt = ST_WAIT;
        else if (op == `MCUEX_OP_SLEEP)
          state_nxt = ST_HALT;
        else
          state_nxt = ST_IDLE;
      end
      ST_WAIT: state_nxt = ((cyc_r + `MCUEX_ONE_CYCLE) == `MCUEX_RET_CYCLES) ? ST_IDLE : ST_WAIT;
      ST_HALT: state_nxt = ST_HALT;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r              <= ST_IDLE;
      cmd_r                <= 16'h0000;
      acc_r                <= `MCUEX_RST_BYTE;
      file_r               <= `MCUEX_RST_BYTE;
      stack_r              <= `MCUEX_RST_PC;
      result_r             <= `MCUEX_RST_BYTE;
      watchdog_r           <= `MCUEX_RST_BYTE;
      presc_cnt_r          <= `MCUEX_RST_BYTE;
      carry_r              <= 1'b0;
      nibble_r             <= 1'b0;
      zero_r               <= 1'b0;
      sleep_ent_r          <= 1'b1;
      expiry_r             <= 1'b1;
      pin_wake_r           <= 1'b0;
      cyc_r                <= 2'h0;
      prescaler_config_out <= `MCUEX_RST_PRESC;
      pin_direction6_out   <= `MCUEX_RST_DIR;
      pin_direction7_out   <= `MCUEX_RST_DIR;
      pc_out               <= `MCUEX_RST_PC;
      pc_load_out          <= 1'b0;
      watchdog_clear_out   <= 1'b0;
      osc_halt_out         <= 1'b0;
      wr_pend_r            <= 1'b0;
      wr_addr_r            <= 8'h00;
      hrdata               <= 32'h00000000;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      pc_load_out        <= 1'b0;
      watchdog_clear_out <= 1'b0;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      // watchdog model, frozen while the oscillator is halted
      if (state_r != ST_HALT) begin
        watchdog_r  <= watchdog_r + 8'h01;
        presc_cnt_r <= presc_cnt_r + 8'h01;
      end
      // bus address phase capture
      wr_pend_r <= xfer & hwrite;
      if (xfer)
        wr_addr_r <= haddr[7:0];
      // read data launched at the address phase so it stands through the data phase
      if (xfer & ~hwrite) begin
        case (haddr[7:0])
          `MCUEX_ADDR_CMD:    hrdata <= {16'h0000, cmd_r};
          `MCUEX_ADDR_ACC:    hrdata <= {24'h000000, acc_r};
          `MCUEX_ADDR_STATUS: hrdata <= {24'h000000, status_w};
          `MCUEX_ADDR_PRESC:  hrdata <= {24'h000000, prescaler_config_out};
          `MCUEX_ADDR_DIR6:   hrdata <= {24'h000000, pin_direction6_out};
          `MCUEX_ADDR_DIR7:   hrdata <= {24'h000000, pin_direction7_out};
          `MCUEX_ADDR_RESULT: hrdata <= {24'h000000, result_r};
          `MCUEX_ADDR_RETPC:  hrdata <= {23'h000000, pc_out};
          `MCUEX_ADDR_FILE:   hrdata <= {24'h000000, file_r};
          `MCUEX_ADDR_WATCH:  hrdata <= {16'h0000, presc_cnt_r, watchdog_r};
          `MCUEX_ADDR_STACK:  hrdata <= {23'h000000, stack_r};
          default:            hrdata <= 32'h00000000;
        endcase
      end
      // write data phase
      if (wr_pend_r) begin
        case (wr_addr_r)
          `MCUEX_ADDR_CMD: begin
            cmd_r <= hwdata[15:0];
            if (state_r == ST_IDLE)
              state_r <= ST_EXEC;
          end
          `MCUEX_ADDR_ACC:   acc_r <= hwdata[7:0];
          `MCUEX_ADDR_FILE:  file_r <= hwdata[7:0];
          `MCUEX_ADDR_STACK: stack_r <= hwdata[8:0];
          `MCUEX_ADDR_STATUS: begin
            carry_r    <= hwdata[`MCUEX_ST_CARRY];
            nibble_r   <= hwdata[`MCUEX_ST_NIBBLE];
            zero_r     <= hwdata[`MCUEX_ST_ZERO];
            pin_wake_r <= hwdata[`MCUEX_ST_PINWAKE];
            // writing a one while halted wakes the core
            if (hwdata[`MCUEX_ST_ASLEEP] && state_r == ST_HALT) begin
              state_r      <= ST_IDLE;
              osc_halt_out <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (state_r == ST_WAIT)
        cyc_r <= cyc_r + `MCUEX_ONE_CYCLE;
      if (state_r == ST_EXEC) begin
        cyc_r <= `MCUEX_ONE_CYCLE;
        if (uses_dest(op)) begin
          result_r <= alu_res;
          if (dest)
            file_r <= alu_res;
          else
            acc_r <= alu_res;
          if ((op == `MCUEX_OP_ROTL) || (op == `MCUEX_OP_ROTR) || (op == `MCUEX_OP_SUB))
            carry_r <= alu_c;
          if (op == `MCUEX_OP_SUB)
            nibble_r <= alu_dc;
        end
        if (sets_zero(op))
          zero_r <= alu_z;
        case (op)
          `MCUEX_OP_LDPRE: prescaler_config_out <= acc_r;
          `MCUEX_OP_RETLIT: begin
            acc_r       <= alu_res;
            result_r    <= alu_res;
            pc_out      <= stack_r;
            pc_load_out <= 1'b1;
          end
          `MCUEX_OP_SLEEP: begin
            watchdog_r         <= `MCUEX_RST_BYTE;
            presc_cnt_r        <= `MCUEX_RST_BYTE;
            watchdog_clear_out <= 1'b1;
            expiry_r    <= 1'b1;
            sleep_ent_r <= 1'b0;
            osc_halt_out <= 1'b1;
          end
          `MCUEX_OP_LDDIR: begin
            if (opnd == `MCUEX_DIR_SEL6)
              pin_direction6_out <= acc_r;
            else if (opnd == `MCUEX_DIR_SEL7)
              pin_direction7_out <= acc_r;
          end
          `MCUEX_OP_XORL: begin
            acc_r    <= alu_res;
            result_r <= alu_res;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- mcuex_monitor.sv ----
// assertion checker for the execute subset block
`timescale 1ns/1ps
module mcuex_monitor (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [7:0]  prescaler_config_out,
  input wire [7:0]  pin_direction6_out,
  input wire [7:0]  pin_direction7_out,
  input wire [8:0]  pc_out,
  input wire        pc_load_out,
  input wire        watchdog_clear_out,
  input wire        osc_halt_out
);
  reg [5:0] cmd_hist_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // recent command writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_hist_r <= 6'h00;
    else
      cmd_hist_r <= {cmd_hist_r[4:0], hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h00)};
  end
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state seen");
  a_presc_cause: assert property ($changed(prescaler_config_out) |-> |cmd_hist_r)
    else $error("prescaler config moved without a command");
  a_dir6_cause: assert property ($changed(pin_direction6_out) |-> |cmd_hist_r)
    else $error("direction 6 moved without a command");
  a_dir7_cause: assert property ($changed(pin_direction7_out) |-> |cmd_hist_r)
    else $error("direction 7 moved without a command");
  a_pc_load_tie: assert property ($changed(pc_out) |-> pc_load_out || $past(pc_load_out))
    else $error("pc moved without load pulse");
  a_load_pulse: assert property (pc_load_out |-> |cmd_hist_r ##1 !pc_load_out)
    else $error("pc load pulse wrong");
  a_clear_pulse: assert property (watchdog_clear_out |-> |cmd_hist_r ##1 !watchdog_clear_out)
    else $error("watchdog clear pulse wrong");
  a_clear_halts: assert property (watchdog_clear_out |-> ##[0:2] osc_halt_out)
    else $error("no halt after sleep");
  a_halt_cause: assert property ($rose(osc_halt_out) |-> watchdog_clear_out || $past(watchdog_clear_out))
    else $error("halt without watchdog clear");
  c_ret: cover property (pc_load_out);
  c_sleep: cover property (watchdog_clear_out);
  c_dir7: cover property ($changed(pin_direction7_out));
endmodule
bind mcuex_core mcuex_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .prescaler_config_out(prescaler_config_out), .pin_direction6_out(pin_direction6_out),
  .pin_direction7_out(pin_direction7_out), .pc_out(pc_out), .pc_load_out(pc_load_out),
  .watchdog_clear_out(watchdog_clear_out), .osc_halt_out(osc_halt_out));

// ---- mcuex_regs.vh ----
// constants for the instruction execute subset block
`ifndef MCUEX_REGS_VH
`define MCUEX_REGS_VH
// ************************************************************
// register byte addresses
// ************************************************************
`define MCUEX_ADDR_CMD      8'h00
`define MCUEX_ADDR_ACC      8'h04
`define MCUEX_ADDR_STATUS   8'h08
`define MCUEX_ADDR_PRESC    8'h0C
`define MCUEX_ADDR_DIR6     8'h10
`define MCUEX_ADDR_DIR7     8'h14
`define MCUEX_ADDR_RESULT   8'h18
`define MCUEX_ADDR_RETPC    8'h1C
`define MCUEX_ADDR_FILE     8'h20
`define MCUEX_ADDR_WATCH    8'h24
`define MCUEX_ADDR_STACK    8'h28
// ************************************************************
// command word fields
// ************************************************************
`define MCUEX_OP_HI         15
`define MCUEX_OP_LO         12
`define MCUEX_DEST_BIT      8
`define MCUEX_OPND_HI       7
`define MCUEX_OPND_LO       0
// ************************************************************
// operation codes
// ************************************************************
`define MCUEX_OP_LDPRE      4'h1
`define MCUEX_OP_RETLIT     4'h2
`define MCUEX_OP_SLEEP      4'h3
`define MCUEX_OP_ROTL       4'h4
`define MCUEX_OP_ROTR       4'h5
`define MCUEX_OP_SUB        4'h6
`define MCUEX_OP_SWAP       4'h7
`define MCUEX_OP_LDDIR      4'h8
`define MCUEX_OP_XORL       4'h9
`define MCUEX_OP_XORF       4'hA
// ************************************************************
// status bit positions
// ************************************************************
`define MCUEX_ST_CARRY      0
`define MCUEX_ST_NIBBLE     1
`define MCUEX_ST_ZERO       2
`define MCUEX_ST_SLEEPENT   3
`define MCUEX_ST_EXPIRY     4
`define MCUEX_ST_PINWAKE    5
`define MCUEX_ST_ASLEEP     6
`define MCUEX_ST_BUSY       7
// ************************************************************
// reset values and timing
// ************************************************************
`define MCUEX_RST_BYTE      8'h00
`define MCUEX_RST_PRESC     8'hFF
`define MCUEX_RST_DIR       8'hFF
`define MCUEX_RST_STATUS    8'h18
`define MCUEX_RST_PC        9'h000
`define MCUEX_DIR_SEL6      8'h06
`define MCUEX_DIR_SEL7      8'h07
`define MCUEX_RET_CYCLES    2'h2
`define MCUEX_ONE_CYCLE     2'h1
`endif

// ---- tb.sv ----
// self-checking testbench for the execute subset block
`timescale 1ns/1ps
`include "mcuex_regs.vh"
module tb;
  localparam [35:0] OPS = 36'h12456789A;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata;
  wire        hready;
  wire [31:0] hrdata;
  wire        hresp_w;
  wire [7:0]  presc_w;
  wire [7:0]  dir6_w;
  wire [7:0]  dir7_w;
  wire [8:0]  pc_w;
  wire        pc_load_w;
  wire        wd_clr_w;
  wire        halt_w;
  integer     num_errors;
  integer     num_checks;
  integer     i;
  integer     n;
  reg  [31:0] rd;
  reg  [7:0]  acc, f, k, acc_e, f_e, presc_e, dir6_e, dir7_e;
  reg  [2:0]  st;
  reg  [8:0]  stk;
  reg  [3:0]  op;
  reg         d;
  reg         pw;
  reg  [10:0] ex;
  reg  [31:0] rnd;
  mcuex_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp_w), .prescaler_config_out(presc_w), .pin_direction6_out(dir6_w),
    .pin_direction7_out(dir7_w), .pc_out(pc_w), .pc_load_out(pc_load_w), .watchdog_clear_out(wd_clr_w),
    .osc_halt_out(halt_w));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wait_rdy;
    integer c;
    begin
      c = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && c < 50) begin
        @(posedge hclk);
        c = c + 1;
      end
      if (c == 50)
        num_errors = num_errors + 1;
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] wd);
    begin
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy;
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
      @(posedge hclk);
    end
  endtask
  task rdchk(input [7:0] a, input string nm, input [31:0] exp);
    begin
      bus(a, 1'b0, 32'h00000000);
      check(nm, rd, exp);
    end
  endtask
  task run_cmd(input [3:0] o, input dd, input [7:0] kk);
    begin
      bus(`MCUEX_ADDR_CMD, 1'b1, {16'h0000, o, 3'b000, dd, kk});
      n = 0;
      rd = 32'h00000080;
      // a sleep never clears busy, so it ends once the asleep bit shows
      while (rd[7] !== 1'b0 && rd[6] !== 1'b1 && n < 20) begin
        bus(`MCUEX_ADDR_STATUS, 1'b0, 32'h00000000);
        n = n + 1;
      end
      if (rd[7] !== 1'b0 && rd[6] !== 1'b1)
        num_errors = num_errors + 1;
    end
  endtask
  function [10:0] model(input [3:0] o, input [7:0] a, input [7:0] fv, input [7:0] kk, input [2:0] s);
    reg [7:0] r;
    reg       c, dc, z;
    begin
      r = a;
      {z, dc, c} = s;
      case (o)
        4'h4: {c, r} = {fv, c};
        4'h5: {r, c} = {c, fv};
        4'h6: begin
          r = fv - a;
          c = fv >= a;
          dc = fv[3:0] >= a[3:0];
          z = r == 8'h00;
        end
        4'h7: r = {fv[3:0], fv[7:4]};
        4'h9: begin
          r = a ^ kk;
          z = r == 8'h00;
        end
        4'hA: begin
          r = a ^ fv;
          z = r == 8'h00;
        end
        4'h2: r = kk;
        default: r = a;
      endcase
      model = {z, dc, c, r};
    end
  endfunction
  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #400000;
    num_errors = num_errors + 1;
    summarize;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = 0;
    hsize = 3'b010;
    num_errors = 0;
    num_checks = 0;
    {presc_e, dir6_e, dir7_e} = 24'hFFFFFF;
    n = $urandom(32'hEF6F40F8);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`MCUEX_ADDR_STATUS, "status reset", 32'h00000018);
    rdchk(8'h3C, "unmapped", 32'h00000000);
    bus(`MCUEX_ADDR_PRESC, 1'b1, 32'h00000000);
    rdchk(`MCUEX_ADDR_PRESC, "presc ro", 32'h000000FF);
    for (i = 0; i < 60; i = i + 1) begin
      rnd = $urandom;
      op = OPS[4 * (rnd[31:24] % 9) +: 4];
      acc = rnd[7:0];
      f = (i % 5 == 0) ? acc : rnd[15:8];
      k = (i % 6 == 0) ? acc : rnd[23:16];
      rnd = $urandom;
      if (op == 4'h8)
        k = 8'h05 + {6'h00, rnd[14:13] % 2'h3};
      {d, st, stk} = rnd[12:0];
      bus(`MCUEX_ADDR_ACC, 1'b1, {24'h0, acc});
      bus(`MCUEX_ADDR_FILE, 1'b1, {24'h0, f});
      bus(`MCUEX_ADDR_STACK, 1'b1, {23'h0, stk});
      bus(`MCUEX_ADDR_STATUS, 1'b1, {27'h0, 2'b11, st});
      run_cmd(op, d, k);
      ex = model(op, acc, f, k, st);
      d = d && ((op >= 4'h4 && op <= 4'h7) || op == 4'hA);
      f_e = d ? ex[7:0] : f;
      acc_e = (op == 4'h1 || op == 4'h8 || d) ? acc : ex[7:0];
      if (op == 4'h1)
        presc_e = acc;
      if (op == 4'h8 && k == 8'h06)
        dir6_e = acc;
      if (op == 4'h8 && k == 8'h07)
        dir7_e = acc;
      rdchk(`MCUEX_ADDR_ACC, "acc", {24'h0, acc_e});
      rdchk(`MCUEX_ADDR_FILE, "file", {24'h0, f_e});
      if (op != 4'h1 && op != 4'h8)
        rdchk(`MCUEX_ADDR_RESULT, "result", {24'h0, ex[7:0]});
      bus(`MCUEX_ADDR_STATUS, 1'b0, 32'h00000000);
      check("flags", {29'h0, rd[2:0]}, {29'h0, ex[10:8]});
      check("presc", {24'h0, presc_w}, {24'h0, presc_e});
      check("dir6", {24'h0, dir6_w}, {24'h0, dir6_e});
      check("dir7", {24'h0, dir7_w}, {24'h0, dir7_e});
      if (op == 4'h2)
        check("pc", {23'h0, pc_w}, {23'h0, stk});
    end
    bus(`MCUEX_ADDR_STATUS, 1'b1, 32'h00000038);
    bus(`MCUEX_ADDR_STATUS, 1'b0, 32'h00000000);
    pw = rd[5];
    run_cmd(`MCUEX_OP_SLEEP, 1'b0, 8'h00);
    check("halt", {31'h0, halt_w}, 32'h00000001);
    bus(`MCUEX_ADDR_STATUS, 1'b0, 32'h00000000);
    check("sleep flags", {29'h0, rd[5:3]}, {29'h0, pw, 2'b10});
    rdchk(`MCUEX_ADDR_WATCH, "watchdog", 32'h00000000);
    bus(`MCUEX_ADDR_STATUS, 1'b1, 32'h00000058);
    repeat (3) @(posedge hclk);
    check("wake", {31'h0, halt_w}, 32'h00000000);
    summarize;
  end
endmodule
